// ==== hdl/tmr_regs.sv ====
// 16-bit timer register block: count, compares, capture, flags, mask, shared high latch
`timescale 1ns/1ps
`include "tmr_consts.svh"

module tmr_regs (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic [`TMR_ADDR_W-1:0] io_addr,
    input  wire logic                   io_wr,
    input  wire logic                   io_rd,
    input  wire tmr_pkg::tmr_byte_t     io_wdata,
    output tmr_pkg::tmr_byte_t          io_rdata,
    input  wire logic                   timer_tick,
    input  wire tmr_pkg::tmr_word_t     count_next,
    input  wire logic                   overflow_event,
    input  wire logic                   top_is_capture,
    input  wire logic                   force_compare_a_strobe,
    input  wire logic                   force_compare_b_strobe,
    input  wire logic                   capture_input_pin,
    input  wire logic                   comparator_out,
    input  wire logic                   capture_from_comparator,
    input  wire logic                   capture_rising_edge,
    input  wire logic                   global_irq_enable,
    input  wire logic                   ack_capture,
    input  wire logic                   ack_compare_a,
    input  wire logic                   ack_compare_b,
    input  wire logic                   ack_overflow,
    output tmr_pkg::tmr_word_t          timer_count,
    output tmr_pkg::tmr_word_t          capture_top_value,
    output logic                        compare_a_event,
    output logic                        compare_b_event,
    output logic                        irq_capture,
    output logic                        irq_compare_a,
    output logic                        irq_compare_b,
    output logic                        irq_overflow
);

    // ---------------------------------------------------------------
    // Reset release
    // ---------------------------------------------------------------
    logic rst_m_r;
    logic rst_s_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_r <= 1'b0;
            rst_s_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_s_r <= rst_m_r;
        end
    end

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    tmr_pkg::tmr_word_t cnt_r;
    tmr_pkg::tmr_word_t cmpa_r;
    tmr_pkg::tmr_word_t cmpb_r;
    tmr_pkg::tmr_word_t cap_r;
    tmr_pkg::tmr_byte_t temp_r;
    tmr_pkg::tmr_byte_t temp_nxt;
    tmr_pkg::tmr_byte_t mask_r;
    tmr_pkg::tmr_byte_t flag_r;
    tmr_pkg::tmr_byte_t flag_nxt;
    tmr_pkg::tmr_byte_t rdata_nxt;
    logic               block_r;
    logic               cmpa_match;
    logic               cmpb_match;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    wire wr_cap_l  = io_wr && (io_addr == `TMR_OFS_CAP_L);
    wire wr_cmpb_l = io_wr && (io_addr == `TMR_OFS_CMPB_L);
    wire wr_cmpa_l = io_wr && (io_addr == `TMR_OFS_CMPA_L);
    wire wr_cnt_l  = io_wr && (io_addr == `TMR_OFS_CNT_L);
    wire wr_flag   = io_wr && (io_addr == `TMR_OFS_FLAG);
    wire wr_mask   = io_wr && (io_addr == `TMR_OFS_MASK);
    wire wr_high   = io_wr && ((io_addr == `TMR_OFS_CAP_H) || (io_addr == `TMR_OFS_CMPB_H)
                     || (io_addr == `TMR_OFS_CMPA_H) || (io_addr == `TMR_OFS_CNT_H));
    wire rd_cnt_l  = io_rd && (io_addr == `TMR_OFS_CNT_L);
    wire rd_cap_l  = io_rd && (io_addr == `TMR_OFS_CAP_L);
    wire tmr_pkg::tmr_word_t wr_word = {temp_r, io_wdata};

    // ---------------------------------------------------------------
    // Capture source
    // ---------------------------------------------------------------
    logic pin_lvl;
    logic cmp_lvl;
    logic src_prev_r;

    tmr_sync u_sync_pin (
        .clk   (clk),
        .rst_n (rst_s_r),
        .pin   (capture_input_pin),
        .level (pin_lvl)
    );

    tmr_sync u_sync_cmp (
        .clk   (clk),
        .rst_n (rst_s_r),
        .pin   (comparator_out),
        .level (cmp_lvl)
    );

    wire src_lvl  = capture_from_comparator ? cmp_lvl : pin_lvl;
    wire src_edge = capture_rising_edge ? (src_lvl && !src_prev_r) : (!src_lvl && src_prev_r);
    // Pin events are disconnected while the capture value serves as TOP
    wire cap_pin_evt = src_edge && !top_is_capture;
    wire cap_top_evt = top_is_capture && timer_tick && (cnt_r == cap_r);

    // ---------------------------------------------------------------
    // Compare units
    // ---------------------------------------------------------------
    tmr_cmp u_cmp_a (
        .clk   (clk),
        .rst_n (rst_s_r),
        .tick  (timer_tick),
        .block (block_r),
        .count (cnt_r),
        .value (cmpa_r),
        .match (cmpa_match)
    );

    tmr_cmp u_cmp_b (
        .clk   (clk),
        .rst_n (rst_s_r),
        .tick  (timer_tick),
        .block (block_r),
        .count (cnt_r),
        .value (cmpb_r),
        .match (cmpb_match)
    );

    // Forced strobes reach the waveform side only, never the flags
    assign compare_a_event = cmpa_match || force_compare_a_strobe;
    assign compare_b_event = cmpb_match || force_compare_b_strobe;

    // ---------------------------------------------------------------
    // Flags and interrupt requests
    // ---------------------------------------------------------------
    wire tmr_pkg::tmr_byte_t flag_set = {2'b00, cap_pin_evt || cap_top_evt, 2'b00,
                                         cmpb_match, cmpa_match, overflow_event};
    wire tmr_pkg::tmr_byte_t flag_clr = {2'b00, ack_capture, 2'b00,
                                         ack_compare_b, ack_compare_a, ack_overflow}
                                        | (wr_flag ? io_wdata : `TMR_RST_BYTE);

    always_comb begin
        // A set in the same cycle as a clear wins
        flag_nxt = ((flag_r & ~flag_clr) | flag_set) & `TMR_IRQ_BITS;
    end

    assign irq_capture   = global_irq_enable && mask_r[`TMR_BIT_CAP]
                           && flag_r[`TMR_BIT_CAP];
    assign irq_compare_b = global_irq_enable && mask_r[`TMR_BIT_CMPB]
                           && flag_r[`TMR_BIT_CMPB];
    assign irq_compare_a = global_irq_enable && mask_r[`TMR_BIT_CMPA]
                           && flag_r[`TMR_BIT_CMPA];
    assign irq_overflow  = global_irq_enable && mask_r[`TMR_BIT_OVF]
                           && flag_r[`TMR_BIT_OVF];

    // ---------------------------------------------------------------
    // Read path and shared high latch
    // ---------------------------------------------------------------
    always_comb begin
        temp_nxt = temp_r;
        if (wr_high) begin
            temp_nxt = io_wdata;
        end else if (rd_cnt_l) begin
            temp_nxt = cnt_r[15:8];
        end else if (rd_cap_l) begin
            temp_nxt = cap_r[15:8];
        end
    end

    always_comb begin
        case (io_addr)
            `TMR_OFS_CAP_L:  rdata_nxt = cap_r[7:0];
            `TMR_OFS_CAP_H:  rdata_nxt = temp_r;
            `TMR_OFS_CMPB_L: rdata_nxt = cmpb_r[7:0];
            `TMR_OFS_CMPB_H: rdata_nxt = cmpb_r[15:8];
            `TMR_OFS_CMPA_L: rdata_nxt = cmpa_r[7:0];
            `TMR_OFS_CMPA_H: rdata_nxt = cmpa_r[15:8];
            `TMR_OFS_CNT_L:  rdata_nxt = cnt_r[7:0];
            `TMR_OFS_CNT_H:  rdata_nxt = temp_r;
            `TMR_OFS_FLAG:   rdata_nxt = flag_r;
            `TMR_OFS_MASK:   rdata_nxt = mask_r;
            default:         rdata_nxt = `TMR_RST_BYTE;
        endcase
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            cnt_r      <= `TMR_RST_WORD;
            cmpa_r     <= `TMR_RST_WORD;
            cmpb_r     <= `TMR_RST_WORD;
            cap_r      <= `TMR_RST_WORD;
            mask_r     <= `TMR_RST_BYTE;
            flag_r     <= `TMR_RST_BYTE;
            temp_r     <= `TMR_RST_BYTE;
            io_rdata   <= `TMR_RST_BYTE;
            block_r    <= 1'b0;
            src_prev_r <= 1'b0;
        end else begin
            temp_r     <= temp_nxt;
            flag_r     <= flag_nxt;
            src_prev_r <= src_lvl;
            if (io_rd) begin
                io_rdata <= rdata_nxt;
            end
            if (wr_cnt_l) begin
                cnt_r <= wr_word;
            end else if (timer_tick) begin
                cnt_r <= count_next;
            end
            // Held until the next timer tick has gone by
            if (wr_cnt_l) begin
                block_r <= 1'b1;
            end else if (timer_tick) begin
                block_r <= 1'b0;
            end
            if (wr_cmpa_l) begin
                cmpa_r <= wr_word;
            end
            if (wr_cmpb_l) begin
                cmpb_r <= wr_word;
            end
            if (cap_pin_evt) begin
                cap_r <= cnt_r;
            end else if (wr_cap_l) begin
                cap_r <= wr_word;
            end
            if (wr_mask) begin
                mask_r <= io_wdata & `TMR_IRQ_BITS;
            end
        end
    end

    assign timer_count       = cnt_r;
    assign capture_top_value = cap_r;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_cnt_commit;
        @(posedge clk) disable iff (!rst_s_r)
        wr_cnt_l |=> cnt_r == {$past(temp_r), $past(io_wdata)};
    endproperty
    a_cnt_commit: assert property (p_cnt_commit)
        else $error("count low write did not commit both bytes");

    property p_temp_high;
        @(posedge clk) disable iff (!rst_s_r)
        wr_high |=> temp_r == $past(io_wdata);
    endproperty
    a_temp_high: assert property (p_temp_high)
        else $error("high byte write missed the shared latch");

    property p_read_low;
        @(posedge clk) disable iff (!rst_s_r)
        rd_cnt_l |=> (temp_r == $past(cnt_r[15:8])) && (io_rdata == $past(cnt_r[7:0]));
    endproperty
    a_read_low: assert property (p_read_low)
        else $error("count low read did not latch high byte");

    property p_block;
        @(posedge clk) disable iff (!rst_s_r)
        (wr_cnt_l || (block_r && !timer_tick)) |=> block_r;
    endproperty
    a_block: assert property (p_block)
        else $error("compare block dropped before the next tick");

    property p_flag_b;
        @(posedge clk) disable iff (!rst_s_r)
        cmpb_match |=> flag_r[`TMR_BIT_CMPB];
    endproperty
    a_flag_b: assert property (p_flag_b)
        else $error("compare B match did not set its flag");

    property p_force_no_flag;
        @(posedge clk) disable iff (!rst_s_r)
        force_compare_a_strobe && !cmpa_match && !flag_r[`TMR_BIT_CMPA] |=> !flag_r[`TMR_BIT_CMPA];
    endproperty
    a_force_no_flag: assert property (p_force_no_flag)
        else $error("forced strobe set compare A flag");

    property p_capture;
        @(posedge clk) disable iff (!rst_s_r)
        cap_pin_evt |=> (cap_r == $past(cnt_r)) && flag_r[`TMR_BIT_CAP];
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture event did not load count");

    property p_cap_top;
        @(posedge clk) disable iff (!rst_s_r)
        cap_top_evt |=> flag_r[`TMR_BIT_CAP];
    endproperty
    a_cap_top: assert property (p_cap_top)
        else $error("reaching capture TOP did not set flag");

    property p_irq_cap;
        @(posedge clk) disable iff (!rst_s_r)
        irq_capture == (global_irq_enable && mask_r[5] && flag_r[5]);
    endproperty
    a_irq_cap: assert property (p_irq_cap)
        else $error("capture request mismatch");

    property p_irq_b;
        @(posedge clk) disable iff (!rst_s_r)
        irq_compare_b == (global_irq_enable && mask_r[2] && flag_r[2]);
    endproperty
    a_irq_b: assert property (p_irq_b)
        else $error("compare B request mismatch");

    property p_irq_a_ovf;
        @(posedge clk) disable iff (!rst_s_r)
        (irq_compare_a == (global_irq_enable && mask_r[1] && flag_r[1]))
        && (irq_overflow == (global_irq_enable && mask_r[0] && flag_r[0]));
    endproperty
    a_irq_a_ovf: assert property (p_irq_a_ovf)
        else $error("compare A or overflow request mismatch");

    property p_ack_clear;
        @(posedge clk) disable iff (!rst_s_r)
        ack_compare_b && !cmpb_match |=> !flag_r[`TMR_BIT_CMPB];
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("vector acknowledge did not clear flag");

    property p_reset_zero;
        @(posedge clk)
        !rst_s_r |-> (cnt_r == 16'h0000) && (cap_r == 16'h0000) && (mask_r == 8'h00)
                     && (cmpa_r == 16'h0000) && (cmpb_r == 16'h0000);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("registers not zero in reset");
endmodule : tmr_regs

// ==== hdl/tmr_consts.svh ====
// Offsets, bit positions and reset values of the timer register block
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

`define TMR_ADDR_W          6
`define TMR_OFS_CAP_L       6'h22
`define TMR_OFS_CAP_H       6'h23
`define TMR_OFS_CMPB_L      6'h24
`define TMR_OFS_CMPB_H      6'h25
`define TMR_OFS_CMPA_L      6'h26
`define TMR_OFS_CMPA_H      6'h27
`define TMR_OFS_CNT_L       6'h28
`define TMR_OFS_CNT_H       6'h29
`define TMR_OFS_FLAG        6'h2A
`define TMR_OFS_MASK        6'h2B

`define TMR_BIT_CAP         5
`define TMR_BIT_CMPB        2
`define TMR_BIT_CMPA        1
`define TMR_BIT_OVF         0
`define TMR_IRQ_BITS        8'h27

`define TMR_RST_WORD        16'h0000
`define TMR_RST_BYTE        8'h00

`endif

// ==== hdl/tmr_pkg.sv ====
// Types shared by the timer register block
package tmr_pkg;
    typedef logic [15:0] tmr_word_t;
    typedef logic [7:0]  tmr_byte_t;
endpackage : tmr_pkg

// ==== hdl/tmr_sync.sv ====
// Three-stage pin synchroniser whose output changes once stages two and three agree
`timescale 1ns/1ps
module tmr_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            s3_r  <= 1'b0;
            level <= 1'b0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level <= s3_r;
            end
        end
    end
endmodule : tmr_sync

// ==== hdl/tmr_cmp.sv ====
// One compare unit: equality with the count, gated by the timer tick and the write block
`timescale 1ns/1ps
module tmr_cmp (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              tick,
    input  wire logic              block,
    input  wire tmr_pkg::tmr_word_t count,
    input  wire tmr_pkg::tmr_word_t value,
    output logic                   match
);
    wire hit = tick && (count == value) && !block;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            match <= 1'b0;
        end else begin
            match <= hit;
        end
    end

    property p_cmp_match;
        @(posedge clk) disable iff (!rst_n)
        tick && (count == value) && !block |=> match;
    endproperty
    a_cmp_match: assert property (p_cmp_match)
        else $error("compare equality did not raise match");

    property p_cmp_block;
        @(posedge clk) disable iff (!rst_n)
        block |=> !match;
    endproperty
    a_cmp_block: assert property (p_cmp_block)
        else $error("match raised while blocked");
endmodule : tmr_cmp

// ==== test/tmr_cpu_model.sv ====
// Processor-side model issuing byte reads and writes on the timer I/O bus
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_cpu_model (
    input  wire logic                   clk,
    input  wire tmr_pkg::tmr_byte_t     io_rdata,
    output logic [`TMR_ADDR_W-1:0]      io_addr,
    output logic                        io_wr,
    output logic                        io_rd,
    output tmr_pkg::tmr_byte_t          io_wdata
);
    initial begin
        io_addr  = 6'h00;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk);
        io_wr    <= 1'b0;
        @(posedge clk);
    endtask : wr

    // Read data is registered at the strobe edge and taken one edge later while it stands
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk);
        io_rd   <= 1'b0;
        @(posedge clk);
        d = io_rdata;
    endtask : rd

    // High byte first into the shared latch, low byte commits the word
    task automatic wr16(input logic [5:0] b, input logic [15:0] w);
        wr(b + 6'h01, w[15:8]);
        wr(b, w[7:0]);
    endtask : wr16

    // Low byte first so a count or capture high byte is latched together with it
    task automatic rd16(input logic [5:0] b, output logic [15:0] w);
        rd(b, w[7:0]);
        rd(b + 6'h01, w[15:8]);
    endtask : rd16
endmodule : tmr_cpu_model

// ==== test/timer16_register_interface_test.sv ====
// Self-checking bench of the timer register block against an integer model
`timescale 1ns/1ps
module timer16_register_interface_test;
    logic               clk;
    logic               rst_n;
    logic [7:0]         pls;
    logic [15:0]        count_next;
    logic               top_cap, pin, cmp_out, cap_sel, cap_rise, gie;
    logic [5:0]         io_addr;
    logic               io_wr, io_rd;
    logic [7:0]         io_wdata, io_rdata, d;
    logic [15:0]        timer_count, capture_top_value, w;
    logic               ev_a_o, ev_b_o, irq_c, irq_a, irq_b, irq_o;
    logic [5:0]         a;
    int                 fail_count, tests_run, cycles, ev_a, ev_b, n0, n1;
    int                 mdl [int];
    int unsigned        seed;

    tmr_cpu_model cpu (.clk(clk), .io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr),
                       .io_rd(io_rd), .io_wdata(io_wdata));

    tmr_regs u_dut (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .timer_tick(pls[0]),
        .count_next(count_next), .overflow_event(pls[1]), .top_is_capture(top_cap),
        .force_compare_a_strobe(pls[2]), .force_compare_b_strobe(pls[3]),
        .capture_input_pin(pin), .comparator_out(cmp_out),
        .capture_from_comparator(cap_sel), .capture_rising_edge(cap_rise),
        .global_irq_enable(gie), .ack_capture(pls[4]), .ack_compare_a(pls[5]),
        .ack_compare_b(pls[6]), .ack_overflow(pls[7]), .timer_count(timer_count),
        .capture_top_value(capture_top_value), .compare_a_event(ev_a_o),
        .compare_b_event(ev_b_o), .irq_capture(irq_c), .irq_compare_a(irq_a),
        .irq_compare_b(irq_b), .irq_overflow(irq_o));

    // ------------------------------------------------------------------
    // Clock, event counting, timeout
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (ev_a_o === 1'b1) ev_a <= ev_a + 1;
        if (ev_b_o === 1'b1) ev_b <= ev_b + 1;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic pulse(input int i);
        @(posedge clk);
        pls[i] <= 1'b1;
        @(posedge clk);
        pls[i] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse

    task automatic flg(input logic [7:0] e);
        cpu.rd(6'h2A, d);
        chk({8'h00, d}, {8'h00, e});
    endtask : flg

    // Drives one level input: 0 capture pin, 1 comparator, other global enable
    task automatic setin(input int i, input logic v);
        @(posedge clk);
        case (i)
            0: pin <= v;
            1: cmp_out <= v;
            default: gie <= v;
        endcase
        repeat (10) @(posedge clk);
    endtask : setin

    task automatic test_done();
        if (fail_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0; pls = 8'h00; count_next = 16'h0000; top_cap = 1'b0; pin = 1'b0;
        cmp_out = 1'b0; cap_sel = 1'b0; cap_rise = 1'b1; gie = 1'b1; seed = 81;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (a = 6'h22; a <= 6'h2B; a++) begin
            cpu.rd(a, d);
            chk({8'h00, d}, 16'h0000);
        end
        cpu.wr(6'h30, 8'hFF);
        cpu.rd(6'h30, d);
        chk({8'h00, d}, 16'h0000);
        // Ticks stay idle while the count is rewritten
        for (a = 6'h22; a <= 6'h28; a += 6'h02) begin
            w = {rnd(), rnd()};
            mdl[a] = int'(w);
            cpu.wr16(a, w);
        end
        d = rnd();
        cpu.wr(6'h2B, d);
        mdl[6'h2B] = int'(d & 8'h27);
        for (a = 6'h22; a <= 6'h28; a += 6'h02) begin
            cpu.rd16(a, w);
            chk(w, mdl[a][15:0]);
        end
        cpu.rd(6'h2B, d);
        chk({8'h00, d}, mdl[6'h2B][15:0]);
        chk(timer_count, mdl[6'h28][15:0]);
        chk(capture_top_value, mdl[6'h22][15:0]);
        cpu.wr(6'h27, 8'h5A);
        cpu.wr(6'h28, 8'hC3);
        chk(timer_count, 16'h5AC3);
        cpu.rd16(6'h26, w);
        chk(w, mdl[6'h26][15:0]);
        cpu.rd(6'h28, d);
        count_next <= 16'hA5A5;
        pulse(0);
        cpu.rd(6'h29, d);
        chk({8'h00, d}, 16'h005A);
        chk(timer_count, 16'hA5A5);
        // Compare units, flags and interrupt gating
        cpu.wr16(6'h26, 16'h1234);
        cpu.wr16(6'h24, 16'h4321);
        cpu.wr(6'h2B, 8'h27);
        cpu.wr(6'h2A, 8'hFF);
        flg(8'h00);
        n0 = ev_a;
        count_next <= 16'h1234;
        pulse(0);
        pulse(0);
        chk(16'(ev_a - n0), 16'h0001);
        flg(8'h02);
        chk({15'h0000, irq_a}, 16'h0001);
        chk({15'h0000, irq_b}, 16'h0000);
        setin(2, 1'b0);
        chk({15'h0000, irq_a}, 16'h0000);
        setin(2, 1'b1);
        cpu.wr(6'h2B, 8'h25);
        chk({15'h0000, irq_a}, 16'h0000);
        cpu.wr(6'h2B, 8'h27);
        cpu.wr(6'h2A, 8'h02);
        flg(8'h00);
        // The first tick still sees the count at compare A, the second reaches B
        count_next <= 16'h4321;
        pulse(0);
        pulse(0);
        flg(8'h06);
        chk({15'h0000, irq_b}, 16'h0001);
        pulse(6);
        flg(8'h02);
        cpu.wr(6'h2A, 8'h02);
        n0 = ev_a;
        n1 = ev_b;
        pulse(2);
        pulse(3);
        chk(16'(ev_a - n0), 16'h0001);
        chk(16'(ev_b - n1), 16'h0001);
        flg(8'h00);
        cpu.wr16(6'h28, 16'h1234);
        count_next <= 16'h1234;
        pulse(0);
        flg(8'h00);
        pulse(0);
        flg(8'h02);
        pulse(1);
        flg(8'h03);
        chk({15'h0000, irq_o}, 16'h0001);
        pulse(7);
        pulse(5);
        flg(8'h00);
        // Capture from pin, comparator and capture-as-TOP
        setin(0, 1'b1);
        chk(capture_top_value, 16'h1234);
        flg(8'h20);
        chk({15'h0000, irq_c}, 16'h0001);
        pulse(4);
        flg(8'h00);
        cap_rise <= 1'b0;
        count_next <= 16'h0BEE;
        pulse(0);
        setin(0, 1'b0);
        cpu.rd16(6'h22, w);
        chk(w, 16'h0BEE);
        cap_sel <= 1'b1;
        cap_rise <= 1'b1;
        count_next <= 16'h0CAB;
        pulse(0);
        setin(1, 1'b1);
        chk(capture_top_value, 16'h0CAB);
        cap_sel <= 1'b0;
        top_cap <= 1'b1;
        count_next <= 16'h0100;
        // This tick finds the count at TOP, so the flag set there is cleared after it
        pulse(0);
        cpu.wr(6'h2A, 8'hFF);
        setin(0, 1'b1);
        flg(8'h00);
        chk(capture_top_value, 16'h0CAB);
        count_next <= 16'h0CAB;
        pulse(0);
        pulse(0);
        flg(8'h20);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(timer_count, 16'h0000);
        cpu.rd(6'h2B, d);
        chk({8'h00, d}, 16'h0000);
        test_done();
    end
endmodule : timer16_register_interface_test
